/* File: core/pdl_top.sv */
// Port 0 and port 2 data latches with pin drive and pin readback
`timescale 1ns/1ns
module pdl_top
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Special register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic reg_rmw,
  output logic [7:0] reg_rdata,
  // Crossbar and drive style
  input wire logic [7:0] crossbar_route_reg_a,
  input wire logic [7:0] crossbar_route_reg_b,
  input wire logic [7:0] crossbar_route_reg_c,
  input wire logic [7:0] crossbar_route_reg_d,
  input wire logic [7:0] p0_periph_en,
  input wire logic [7:0] p0_periph_val,
  input wire logic [7:0] p2_periph_en,
  input wire logic [7:0] p2_periph_val,
  input wire logic [7:0] port_zero_drive_style,
  input wire logic [7:0] port_two_drive_style,
  // External memory interface
  input wire logic emif_p0_en,
  input wire logic emif_wr_n,
  input wire logic emif_rd_n,
  input wire logic emif_ale,
  input wire logic emif_p2_en,
  input wire logic [7:0] emif_addr,
  // Pins
  input wire logic [7:0] p0_pin_in,
  output logic [7:0] p0_pin_out,
  output logic [7:0] p0_pin_oe,
  input wire logic [7:0] p2_pin_in,
  output logic [7:0] p2_pin_out,
  output logic [7:0] p2_pin_oe
);
  // ****************************************
  // Latches
  // ****************************************
  logic [7:0] port_zero_latch_q;
  logic [7:0] port_two_latch_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      port_zero_latch_q <= pdl_pkg::PDL_LATCH_RESET;
    else if (reg_wr && reg_addr == pdl_pkg::PDL_ADDR_PORT_ZERO)
      port_zero_latch_q <= reg_wdata; // [R1]
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      port_two_latch_q <= pdl_pkg::PDL_LATCH_RESET;
    else if (reg_wr && reg_addr == pdl_pkg::PDL_ADDR_PORT_TWO)
      port_two_latch_q <= reg_wdata; // [R1]
  end
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [7:0] p0_s1_q, p0_s2_q, p0_s3_q, p0_lvl_q;
  logic [7:0] p2_s1_q, p2_s2_q, p2_s3_q, p2_lvl_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      p0_s1_q <= 8'h00;
      p0_s2_q <= 8'h00;
      p0_s3_q <= 8'h00;
      p2_s1_q <= 8'h00;
      p2_s2_q <= 8'h00;
      p2_s3_q <= 8'h00;
    end
    else
    begin
      p0_s1_q <= p0_pin_in;
      p0_s2_q <= p0_s1_q;
      p0_s3_q <= p0_s2_q;
      p2_s1_q <= p2_pin_in;
      p2_s2_q <= p2_s1_q;
      p2_s3_q <= p2_s2_q;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      p0_lvl_q <= 8'h00;
      p2_lvl_q <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (p0_s2_q[i] == p0_s3_q[i])
          p0_lvl_q[i] <= p0_s3_q[i];
        if (p2_s2_q[i] == p2_s3_q[i])
          p2_lvl_q[i] <= p2_s3_q[i];
      end
    end
  end
  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] rdata_d;
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_addr == pdl_pkg::PDL_ADDR_PORT_ZERO)
      rdata_d = reg_rmw ? port_zero_latch_q : p0_lvl_q; // [R4] [R5]
    else if (reg_addr == pdl_pkg::PDL_ADDR_PORT_TWO)
      rdata_d = reg_rmw ? port_two_latch_q : p2_lvl_q; // [R4] [R5]
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_d;
  end
  // ****************************************
  // Routing and pin drive
  // ****************************************
  pdl_pin_if p0 ();
  pdl_pin_if p2 ();
  logic [7:0] emif_p0_val;
  always_comb
  begin
    emif_p0_val = 8'h00;
    emif_p0_val[pdl_pkg::PDL_EMIF_WR_BIT] = emif_wr_n;
    emif_p0_val[pdl_pkg::PDL_EMIF_RD_BIT] = emif_rd_n;
    emif_p0_val[pdl_pkg::PDL_EMIF_ALE_BIT] = emif_ale;
  end
  // Memory interface takes priority over crossbar peripherals
  assign p0.latch = port_zero_latch_q;
  assign p0.route_en = (emif_p0_en ? pdl_pkg::PDL_EMIF_P0_MASK : 8'h00) | p0_periph_en; // [R6] [R2]
  assign p0.route_val = emif_p0_en ? ((emif_p0_val & pdl_pkg::PDL_EMIF_P0_MASK)
    | (p0_periph_val & ~pdl_pkg::PDL_EMIF_P0_MASK)) : p0_periph_val; // [R6]
  assign p0.push_pull = port_zero_drive_style;
  assign p2.latch = port_two_latch_q;
  assign p2.route_en = emif_p2_en ? 8'hff : p2_periph_en; // [R6] [R2]
  assign p2.route_val = emif_p2_en ? emif_addr : p2_periph_val; // [R6]
  assign p2.push_pull = port_two_drive_style;
  pdl_pin_drv u_p0 (.pins(p0));
  pdl_pin_drv u_p2 (.pins(p2));
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      p0_pin_out <= 8'hff;
      p0_pin_oe <= 8'h00;
      p2_pin_out <= 8'hff;
      p2_pin_oe <= 8'h00;
    end
    else
    begin
      p0_pin_out <= p0.pin_out; // [R3]
      p0_pin_oe <= p0.pin_oe;
      p2_pin_out <= p2.pin_out; // [R3]
      p2_pin_oe <= p2.pin_oe;
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  AST_WRITE_P0: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    reg_wr && reg_addr == pdl_pkg::PDL_ADDR_PORT_ZERO |=> port_zero_latch_q == $past(reg_wdata))
    else $error("port zero latch not written");
  AST_WRITE_P2: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    reg_wr && reg_addr == pdl_pkg::PDL_ADDR_PORT_TWO |=> port_two_latch_q == $past(reg_wdata))
    else $error("port two latch not written");
  AST_LOW_DRIVE: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    !emif_p2_en && p2_periph_en == 8'h00 && !port_two_latch_q[0]
    |=> p2_pin_oe[0] && !p2_pin_out[0])
    else $error("latch zero does not drive low");
  AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    !emif_p2_en && p2_periph_en == 8'h00 && port_two_latch_q[1] && !port_two_drive_style[1]
    |=> !p2_pin_oe[1])
    else $error("open drain high still driven");
  AST_READ_PIN: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    reg_rd && !reg_rmw && reg_addr == pdl_pkg::PDL_ADDR_PORT_TWO |=> reg_rdata == $past(p2_lvl_q))
    else $error("read does not return pins");
  AST_READ_RMW: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    reg_rd && reg_rmw && reg_addr == pdl_pkg::PDL_ADDR_PORT_ZERO
    |=> reg_rdata == $past(port_zero_latch_q))
    else $error("rmw read does not return latch");
  AST_EMIF_ADDR: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
    emif_p2_en |=> p2_pin_out == $past(emif_addr))
    else $error("address not on port two");
  AST_PERIPH: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    !emif_p0_en && p0_periph_en[0] |=> p0_pin_out[0] == $past(p0_periph_val[0]))
    else $error("peripheral pin follows latch");
endmodule

/* File: core/pdl_pkg.sv */
// Package of constants for the port data latch block
//
// Functional notes
// R1 - Each port register holds eight latch bits; bit n steers pin n.
// R2 - Writes reach pins via crossbar routing; peripheral-claimed pins ignore the latch.
// R3 - Latch 0 drives low; latch 1 drives high, or floats when open-drain.
// R4 - Register reads return live pin levels, regardless of crossbar routing.
// R5 - Read phase of read-modify-write returns latch contents, not pins.
// R6 - External memory interface overrides latch: strobes on port 0 bits 7-5, address on port 2.
package pdl_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] PDL_ADDR_PORT_ZERO = 8'h80;
  localparam logic [7:0] PDL_ADDR_PORT_TWO = 8'ha0;
  localparam logic [7:0] PDL_LATCH_RESET = 8'hff;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int PDL_EMIF_WR_BIT = 7;
  localparam int PDL_EMIF_RD_BIT = 6;
  localparam int PDL_EMIF_ALE_BIT = 5;
  localparam logic [7:0] PDL_EMIF_P0_MASK = 8'he0;
endpackage

/* File: core/pdl_pin_if.sv */
// Interface carrying one port's pin signals
`timescale 1ns/1ns
interface pdl_pin_if;
  logic [7:0] latch;
  logic [7:0] route_en;
  logic [7:0] route_val;
  logic [7:0] push_pull;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  modport drv (input latch, input route_en, input route_val, input push_pull,
    output pin_out, output pin_oe);
  modport src (output latch, output route_en, output route_val, output push_pull,
    input pin_out, input pin_oe);
endinterface

/* File: core/pdl_pin_drv.sv */
// Pin driver for one eight-bit port
`timescale 1ns/1ns
module pdl_pin_drv
(
  pdl_pin_if.drv pins
);
  logic [7:0] val;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      val[i] = pins.route_en[i] ? pins.route_val[i] : pins.latch[i]; // [R2]
      pins.pin_out[i] = val[i];
      pins.pin_oe[i] = !val[i] || pins.push_pull[i]; // [R3]
    end
  end
endmodule

/* File: dv/pdl_ext_model.sv */
// Model of the circuitry wired to one port's pins
`timescale 1ns/1ns
module pdl_ext_model
(
  // Device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // External drivers
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // Resolved level
  output logic [7:0] pin_lvl
);
  // Undriven pins rest on the weak pull-up
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
endmodule

/* File: dv/tb_top.sv */
// Self-checking testbench for the port data latch block
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, reg_rmw = 1'b0;
  logic [7:0] crossbar_route_reg_a, crossbar_route_reg_b, crossbar_route_reg_c;
  logic [7:0] crossbar_route_reg_d, emif_addr = 8'h00;
  logic emif_p0_en = 1'b0, emif_p2_en = 1'b0, emif_wr_n = 1'b1, emif_rd_n = 1'b1;
  logic emif_ale = 1'b0;
  logic [7:0] pe [2], pv [2], ds [2], ee [2], ev [2], po [2], oe [2], lvl [2], adr [2];
  logic [7:0] l, e, dr;
  logic [7:0] exp_q [$];
  int n_errors = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  pdl_top pdl_top_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rmw(reg_rmw), .reg_rdata(reg_rdata),
    .crossbar_route_reg_a(crossbar_route_reg_a), .crossbar_route_reg_b(crossbar_route_reg_b),
    .crossbar_route_reg_c(crossbar_route_reg_c), .crossbar_route_reg_d(crossbar_route_reg_d),
    .emif_p0_en(emif_p0_en), .emif_wr_n(emif_wr_n), .emif_rd_n(emif_rd_n),
    .emif_ale(emif_ale), .emif_p2_en(emif_p2_en), .emif_addr(emif_addr),
    .p0_periph_en(pe[0]), .p0_periph_val(pv[0]),
    .p2_periph_en(pe[1]), .p2_periph_val(pv[1]), .port_zero_drive_style(ds[0]),
    .port_two_drive_style(ds[1]), .p0_pin_in(lvl[0]), .p0_pin_out(po[0]),
    .p0_pin_oe(oe[0]), .p2_pin_in(lvl[1]), .p2_pin_out(po[1]), .p2_pin_oe(oe[1]));
  for (genvar g = 0; g < 2; g++)
  begin : g_ext
    pdl_ext_model pdl_ext_model_inst (.pin_out(po[g]), .pin_oe(oe[g]), .ext_en(ee[g]),
      .ext_val(ev[g]), .pin_lvl(lvl[g]));
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    n_tests++;
    if ((got & m) !== (exp & m))
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] x);
    @(negedge clk);
    reg_addr = a;
    reg_rmw = m;
    reg_rd = 1'b1;
    exp_q.push_back(x);
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
  endtask
  task automatic results();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Read data scoreboard
  always @(posedge clk)
  begin
    if (reg_rd === 1'b1)
    begin
      @(negedge clk);
      cmp(reg_rdata, exp_q.pop_front(), 8'hff);
    end
  end
  initial
  begin
    #10000;
    n_errors++;
    results();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(32'h3120));
    {crossbar_route_reg_a, crossbar_route_reg_b} = 16'(16'h0 | $urandom);
    {crossbar_route_reg_c, crossbar_route_reg_d} = 16'(16'h0 | $urandom);
    adr[0] = pdl_pkg::PDL_ADDR_PORT_ZERO;
    adr[1] = pdl_pkg::PDL_ADDR_PORT_TWO;
    for (int p = 0; p < 2; p++)
      {pe[p], pv[p], ds[p], ee[p], ev[p]} = 40'h0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      rd(adr[p], 1'b1, pdl_pkg::PDL_LATCH_RESET);
      cmp(po[p], 8'hff, 8'hff);
      cmp(oe[p], 8'h00, 8'hff);
    end
    $display("reset test done");
    repeat (6)
    for (int p = 0; p < 2; p++)
    begin
      l = 8'($urandom);
      ds[p] = 8'($urandom);
      ee[p] = 8'($urandom);
      ev[p] = 8'($urandom);
      wr(adr[p], l);
      dr = ~l | ds[p];
      cmp(po[p], l, 8'hff);
      cmp(oe[p], dr, 8'hff);
      e = (dr & l) | (~dr & ((ee[p] & ev[p]) | ~ee[p]));
      repeat (3) @(negedge clk);
      rd(adr[p], 1'b0, e);
      rd(adr[p], 1'b1, l);
      pe[p] = 8'($urandom);
      pv[p] = 8'($urandom);
      repeat (2) @(negedge clk);
      cmp(po[p], (pe[p] & pv[p]) | (~pe[p] & l), 8'hff);
      pe[p] = 8'h00;
      wr(8'h90, ~l);
      rd(8'h90, 1'b0, 8'h00);
      rd(adr[p], 1'b1, l);
    end
    $display("latch test done");
    {emif_wr_n, emif_rd_n, emif_ale, emif_addr} = 11'($urandom);
    emif_p0_en = 1'b1;
    emif_p2_en = 1'b1;
    repeat (2) @(negedge clk);
    cmp(po[0], {emif_wr_n, emif_rd_n, emif_ale, 5'h00}, pdl_pkg::PDL_EMIF_P0_MASK);
    cmp(po[1], emif_addr, 8'hff);
    $display("memory interface test done");
    results();
  end
endmodule
